// File: design/atrc_cfg.svh
`ifndef ATRC_CFG_SVH
`define ATRC_CFG_SVH

// geometry
`define ATRC_NUM_CHAN 21
`define ATRC_NUM_CMP 4
`define ATRC_NUM_TRIG_REG 11
`define ATRC_HIGH_CHAN_FIRST 16

// byte offsets, one aligned 32-bit word per register
`define ATRC_OFS_IRQ_EN_HIGH 9'h000
`define ATRC_OFS_READY_LOW 9'h004
`define ATRC_OFS_READY_HIGH 9'h008
`define ATRC_OFS_TRIG_BASE 9'h010
`define ATRC_OFS_CMP_BASE 9'h040
`define ATRC_CMP_STRIDE 9'h020
`define ATRC_OFS_CMP_CON 9'h000
`define ATRC_OFS_CMP_MASK_LOW 9'h004
`define ATRC_OFS_CMP_MASK_HIGH 9'h008
`define ATRC_OFS_CMP_LOW_THR 9'h00C
`define ATRC_OFS_CMP_HIGH_THR 9'h010
`define ATRC_OFS_RESULT_BASE 9'h100

// reset values
`define ATRC_RST_WORD 16'h0000
`define ATRC_RST_CODE 5'h00

// trigger select field positions
`define ATRC_TRIG_EVEN_LSB 0
`define ATRC_TRIG_ODD_LSB 8

// compare control field positions
`define ATRC_CON_CHAN_LSB 8
`define ATRC_CON_ON 7
`define ATRC_CON_IE 6
`define ATRC_CON_STAT 5
`define ATRC_CON_WINDOW 4
`define ATRC_CON_AT_HIGH 3
`define ATRC_CON_BELOW_HIGH 2
`define ATRC_CON_AT_LOW 1
`define ATRC_CON_BELOW_LOW 0

// trigger source codes
`define ATRC_TRG_NONE 5'h00
`define ATRC_TRG_SW_COMMON 5'h01
`define ATRC_TRG_SW_LEVEL 5'h02
`define ATRC_TRG_PWM_FIRST 5'h04
`define ATRC_TRG_CCP_FIRST 5'h14
`define ATRC_TRG_SEC_PWM_FIRST 5'h18
`define ATRC_TRG_CELL_PRI 5'h1C
`define ATRC_TRG_CELL_SEC 5'h1D
`define ATRC_TRG_SEQUENCER 5'h1E
`define ATRC_TRG_EXTERNAL 5'h1F

`endif

// File: design/atrc_pkg.sv
package atrc_pkg;
   typedef logic [15:0] atrc_word_t;
   typedef logic [4:0] atrc_code_t;
   typedef logic [20:0] atrc_chan_vec_t;
endpackage

// File: design/atrc_top.sv
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "atrc_cfg.svh"
module atrc_top
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic conv_valid,
   input wire logic [4:0] conv_channel,
   input wire logic [15:0] conv_data,
   input wire logic sw_common_trig,
   input wire logic sw_level_trig,
   input wire logic [7:0] pwm_trig,
   input wire logic [3:0] capture_compare_unit_irq,
   input wire logic [3:0] sec_pwm_trig2,
   input wire logic logic_cell_one_pri,
   input wire logic logic_cell_one_sec,
   input wire logic trigger_sequencer,
   input wire logic external_trigger_input,
   output atrc_pkg::atrc_chan_vec_t chan_trigger,
   output logic [4:0] chan_irq_high,
   output logic common_irq
);

   atrc_pkg::atrc_chan_vec_t chan_result_ready_r;
   logic [4:0] chan_irq_enable_r;
   atrc_pkg::atrc_code_t trigger_source_sel_r [`ATRC_NUM_CHAN];
   atrc_pkg::atrc_word_t result_buffer_r [`ATRC_NUM_CHAN];
   atrc_pkg::atrc_code_t event_channel_number_r [`ATRC_NUM_CMP];
   logic [7:0] cmp_ctrl_r [`ATRC_NUM_CMP];
   atrc_pkg::atrc_chan_vec_t cmp_mask_r [`ATRC_NUM_CMP];
   atrc_pkg::atrc_word_t low_threshold_r [`ATRC_NUM_CMP];
   atrc_pkg::atrc_word_t high_threshold_r [`ATRC_NUM_CMP];
   logic ext_meta_r;
   logic ext_sync_r;
   logic ack_r;
   logic [31:0] dat_r;
   logic [31:0] dat_nxt;
   logic access;
   logic wr;
   logic rd;
   logic conv_ok;
   logic [31:0] src_vec;
   logic [`ATRC_NUM_CMP-1:0] cmp_hit;
   logic [`ATRC_NUM_CMP-1:0] cmp_con_read;

   // one-wait-state classic slave; effects happen on the accepting edge
   assign access = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr = access && wb_we_i;
   assign rd = access && !wb_we_i;
   assign conv_ok = conv_valid && (conv_channel < 5'(`ATRC_NUM_CHAN));

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
      merge16 = old;
      if (sel[0])
      begin
         merge16[7:0] = d[7:0];
      end
      if (sel[1])
      begin
         merge16[15:8] = d[15:8];
      end
   endfunction

   function automatic logic is_addr(input logic [8:0] a, input logic [8:0] ofs);
      is_addr = (a[8:2] == ofs[8:2]);
   endfunction

   function automatic logic [8:0] cmp_addr(input int x, input logic [8:0] ofs);
      cmp_addr = 9'(`ATRC_OFS_CMP_BASE + 9'(x) * `ATRC_CMP_STRIDE + ofs);
   endfunction

   function automatic logic [8:0] trig_addr(input int c);
      trig_addr = 9'(`ATRC_OFS_TRIG_BASE + 9'(4 * (c / 2)));
   endfunction

   function automatic int trig_lsb(input int c);
      trig_lsb = (c % 2 == 1) ? `ATRC_TRIG_ODD_LSB : `ATRC_TRIG_EVEN_LSB;
   endfunction

   // pin input: two flops before use
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ext_meta_r <= 1'b0;
         ext_sync_r <= 1'b0;
      end
      else
      begin
         ext_meta_r <= external_trigger_input;
         ext_sync_r <= ext_meta_r;
      end
   end

   // source table indexed directly by trigger code; reserved codes tied low
   always_comb
   begin
      src_vec = 32'h00000000;
      src_vec[`ATRC_TRG_NONE] = 1'b0;
      src_vec[`ATRC_TRG_SW_COMMON] = sw_common_trig;
      src_vec[`ATRC_TRG_SW_LEVEL] = sw_level_trig;
      src_vec[`ATRC_TRG_PWM_FIRST +: 8] = pwm_trig;
      src_vec[`ATRC_TRG_CCP_FIRST +: 4] = capture_compare_unit_irq;
      src_vec[`ATRC_TRG_SEC_PWM_FIRST +: 4] = sec_pwm_trig2;
      src_vec[`ATRC_TRG_CELL_PRI] = logic_cell_one_pri;
      src_vec[`ATRC_TRG_CELL_SEC] = logic_cell_one_sec;
      src_vec[`ATRC_TRG_SEQUENCER] = trigger_sequencer;
      src_vec[`ATRC_TRG_EXTERNAL] = ext_sync_r;
      // codes 3 and 12..19 stay zero: no trigger
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         chan_trigger <= '0;
      end
      else
      begin
         for (int c = 0; c < `ATRC_NUM_CHAN; c++)
         begin
            chan_trigger[c] <= src_vec[trigger_source_sel_r[c]];
         end
      end
   end

   // trigger select registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int c = 0; c < `ATRC_NUM_CHAN; c++)
         begin
            trigger_source_sel_r[c] <= `ATRC_RST_CODE;
         end
      end
      else if (wr)
      begin
         // lane follows the field: even channel in lane 0, odd channel in lane 1
         for (int c = 0; c < `ATRC_NUM_CHAN; c++)
         begin
            if (is_addr(wb_adr_i, trig_addr(c)) && wb_sel_i[c % 2])
            begin
               trigger_source_sel_r[c] <= wb_dat_i[trig_lsb(c) +: 5];
            end
         end
      end
   end

   // interrupt enable for upper channels
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         chan_irq_enable_r <= 5'h00;
      end
      else if (wr && wb_sel_i[0] && is_addr(wb_adr_i, `ATRC_OFS_IRQ_EN_HIGH))
      begin
         chan_irq_enable_r <= wb_dat_i[4:0];
      end
   end

   // result buffers and ready flags; a completing conversion beats a same-cycle buffer read
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         chan_result_ready_r <= '0;
         for (int c = 0; c < `ATRC_NUM_CHAN; c++)
         begin
            result_buffer_r[c] <= `ATRC_RST_WORD;
         end
      end
      else
      begin
         for (int c = 0; c < `ATRC_NUM_CHAN; c++)
         begin
            if (conv_ok && conv_channel == 5'(c))
            begin
               result_buffer_r[c] <= conv_data;
               chan_result_ready_r[c] <= 1'b1;
            end
            else if (rd && is_addr(wb_adr_i, 9'(`ATRC_OFS_RESULT_BASE + 9'(4 * c))))
            begin
               chan_result_ready_r[c] <= 1'b0;
            end
         end
      end
   end

   // comparison of the incoming result against each comparator's setup
   always_comb
   begin
      for (int x = 0; x < `ATRC_NUM_CMP; x++)
      begin
         cmp_hit[x] = conv_ok && cmp_ctrl_r[x][`ATRC_CON_ON] && cmp_mask_r[x][conv_channel]
            && ((cmp_ctrl_r[x][`ATRC_CON_WINDOW] && conv_data >= low_threshold_r[x]
                 && conv_data < high_threshold_r[x])
             || (cmp_ctrl_r[x][`ATRC_CON_AT_HIGH] && conv_data >= high_threshold_r[x])
             || (cmp_ctrl_r[x][`ATRC_CON_BELOW_HIGH] && conv_data < high_threshold_r[x])
             || (cmp_ctrl_r[x][`ATRC_CON_AT_LOW] && conv_data >= low_threshold_r[x])
             || (cmp_ctrl_r[x][`ATRC_CON_BELOW_LOW] && conv_data < low_threshold_r[x]));
         cmp_con_read[x] = rd && wb_sel_i[1] && is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_CON));
      end
   end

   // comparator control, masks and thresholds
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int x = 0; x < `ATRC_NUM_CMP; x++)
         begin
            cmp_ctrl_r[x] <= 8'h00;
            cmp_mask_r[x] <= '0;
            low_threshold_r[x] <= `ATRC_RST_WORD;
            high_threshold_r[x] <= `ATRC_RST_WORD;
            event_channel_number_r[x] <= `ATRC_RST_CODE;
         end
      end
      else
      begin
         for (int x = 0; x < `ATRC_NUM_CMP; x++)
         begin
            if (wr && wb_sel_i[0] && is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_CON)))
            begin
               cmp_ctrl_r[x][`ATRC_CON_ON] <= wb_dat_i[`ATRC_CON_ON];
               cmp_ctrl_r[x][`ATRC_CON_IE] <= wb_dat_i[`ATRC_CON_IE];
               cmp_ctrl_r[x][4:0] <= wb_dat_i[4:0];
            end
            // event flag: set wins over the read clear; disable clears it
            if (wr && wb_sel_i[0] && is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_CON))
                && !wb_dat_i[`ATRC_CON_ON])
            begin
               cmp_ctrl_r[x][`ATRC_CON_STAT] <= 1'b0;
            end
            else if (cmp_hit[x])
            begin
               cmp_ctrl_r[x][`ATRC_CON_STAT] <= 1'b1;
            end
            else if (cmp_con_read[x])
            begin
               cmp_ctrl_r[x][`ATRC_CON_STAT] <= 1'b0;
            end
            if (cmp_hit[x])
            begin
               event_channel_number_r[x] <= conv_channel;
            end
            if (wr && is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_MASK_LOW)))
            begin
               cmp_mask_r[x][15:0] <= merge16(cmp_mask_r[x][15:0], wb_dat_i, wb_sel_i);
            end
            if (wr && wb_sel_i[0] && is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_MASK_HIGH)))
            begin
               cmp_mask_r[x][20:16] <= wb_dat_i[4:0];
            end
            if (wr && is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_LOW_THR)))
            begin
               low_threshold_r[x] <= merge16(low_threshold_r[x], wb_dat_i, wb_sel_i);
            end
            if (wr && is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_HIGH_THR)))
            begin
               high_threshold_r[x] <= merge16(high_threshold_r[x], wb_dat_i, wb_sel_i);
            end
         end
      end
   end

   // interrupts: registered so outputs come straight from flops
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         chan_irq_high <= 5'h00;
         common_irq <= 1'b0;
      end
      else
      begin
         chan_irq_high <= chan_result_ready_r[20:16] & chan_irq_enable_r;
         common_irq <= (|(chan_result_ready_r[20:16] & chan_irq_enable_r))
            || (cmp_ctrl_r[0][`ATRC_CON_STAT] && cmp_ctrl_r[0][`ATRC_CON_IE])
            || (cmp_ctrl_r[1][`ATRC_CON_STAT] && cmp_ctrl_r[1][`ATRC_CON_IE])
            || (cmp_ctrl_r[2][`ATRC_CON_STAT] && cmp_ctrl_r[2][`ATRC_CON_IE])
            || (cmp_ctrl_r[3][`ATRC_CON_STAT] && cmp_ctrl_r[3][`ATRC_CON_IE]);
      end
   end

   // read mux; anything unmapped or unimplemented reads zero
   always_comb
   begin
      dat_nxt = 32'h00000000;
      if (is_addr(wb_adr_i, `ATRC_OFS_IRQ_EN_HIGH))
      begin
         dat_nxt[4:0] = chan_irq_enable_r;
      end
      if (is_addr(wb_adr_i, `ATRC_OFS_READY_LOW))
      begin
         dat_nxt[15:0] = chan_result_ready_r[15:0];
      end
      if (is_addr(wb_adr_i, `ATRC_OFS_READY_HIGH))
      begin
         dat_nxt[4:0] = chan_result_ready_r[20:16];
      end
      for (int x = 0; x < `ATRC_NUM_CMP; x++)
      begin
         if (is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_CON)))
         begin
            dat_nxt[`ATRC_CON_CHAN_LSB +: 5] = event_channel_number_r[x];
            dat_nxt[7:0] = cmp_ctrl_r[x];
         end
         if (is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_MASK_LOW)))
         begin
            dat_nxt[15:0] = cmp_mask_r[x][15:0];
         end
         if (is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_MASK_HIGH)))
         begin
            dat_nxt[4:0] = cmp_mask_r[x][20:16];
         end
         if (is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_LOW_THR)))
         begin
            dat_nxt[15:0] = low_threshold_r[x];
         end
         if (is_addr(wb_adr_i, cmp_addr(x, `ATRC_OFS_CMP_HIGH_THR)))
         begin
            dat_nxt[15:0] = high_threshold_r[x];
         end
      end
      for (int c = 0; c < `ATRC_NUM_CHAN; c++)
      begin
         if (is_addr(wb_adr_i, trig_addr(c)))
         begin
            dat_nxt[trig_lsb(c) +: 5] = trigger_source_sel_r[c];
         end
         if (is_addr(wb_adr_i, 9'(`ATRC_OFS_RESULT_BASE + 9'(4 * c))))
         begin
            dat_nxt[15:0] = result_buffer_r[c];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end
      else
      begin
         ack_r <= access;
         if (rd)
         begin
            dat_r <= dat_nxt;
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;

endmodule

// File: bench/atrc_sva.sv
`timescale 1ns/1ps
`include "atrc_cfg.svh"
module atrc_sva
(
   input wire logic clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic conv_valid,
   input wire logic [4:0] conv_channel,
   input wire logic [15:0] conv_data,
   input wire logic sw_common_trig,
   input wire logic sw_level_trig,
   input wire logic [7:0] pwm_trig,
   input wire logic [3:0] capture_compare_unit_irq,
   input wire logic [3:0] sec_pwm_trig2,
   input wire logic logic_cell_one_pri,
   input wire logic logic_cell_one_sec,
   input wire logic trigger_sequencer,
   input wire logic external_trigger_input,
   input wire atrc_pkg::atrc_chan_vec_t chan_trigger,
   input wire logic [4:0] chan_irq_high,
   input wire logic common_irq
);
   logic [8:0] a;
   logic rd;
   assign a = {wb_adr_i[8:2], 2'b00};
   assign rd = wb_ack_o && !wb_we_i;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   AST_RD_UPPER_ZERO: assert property (rd |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read bits not zero");
   AST_IRQEN_ZERO: assert property (rd && a == `ATRC_OFS_IRQ_EN_HIGH |-> wb_dat_o[15:5] == 11'h000)
      else $error("irq enable spare bits set");
   AST_READY_HIGH_ZERO: assert property (rd && a == `ATRC_OFS_READY_HIGH |-> wb_dat_o[15:5] == 11'h000)
      else $error("ready high spare bits set");
   AST_TRIG_ZERO: assert property (rd && a >= `ATRC_OFS_TRIG_BASE && a < 9'h03C
      |-> wb_dat_o[15:13] == 3'h0 && wb_dat_o[7:5] == 3'h0)
      else $error("trigger select spare bits set");
   AST_CON_ZERO: assert property (rd && a >= 9'h040 && a < 9'h0C0 && a[4:0] == 5'h00 |-> wb_dat_o[15:13] == 3'h0)
      else $error("control spare bits set");
   AST_MASK_HIGH_ZERO: assert property (rd && a >= 9'h040 && a < 9'h0C0 && a[4:0] == 5'h08
      |-> wb_dat_o[15:5] == 11'h000)
      else $error("mask high spare bits set");
   AST_HIGH_IRQ_COMMON: assert property (|chan_irq_high |-> common_irq)
      else $error("channel irq without common irq");
   AST_QUIET_AFTER_RESET: assert property ($fell(reset) |-> chan_trigger == 21'h0 && !common_irq)
      else $error("outputs active after reset");
   cover property (rd);
   cover property (common_irq);
   cover property (|chan_trigger);
endmodule

// File: bench/atrc_core_model.sv
`timescale 1ns/1ps
module atrc_core_model
(
   input wire logic clk,
   output logic conv_valid,
   output logic [4:0] conv_channel,
   output logic [15:0] conv_data,
   output logic [31:0] src
);
   initial
   begin
      conv_valid = 1'b0;
      conv_channel = 5'h00;
      conv_data = 16'h0000;
      src = 32'h0000_0000;
   end
   task convert(input logic [4:0] c, input logic [15:0] d);
      @(posedge clk);
      conv_valid <= 1'b1;
      conv_channel <= c;
      conv_data <= d;
      @(posedge clk);
      conv_valid <= 1'b0;
      // stale qualifiers are inverted so nothing leans on them
      conv_channel <= ~c;
      conv_data <= ~d;
   endtask
   task set_src(input logic [31:0] v);
      @(posedge clk);
      src <= v;
   endtask
endmodule

// File: bench/atrc_top_test.sv
`timescale 1ns/1ps
`include "atrc_cfg.svh"
module atrc_top_test;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [8:0] adr = 9'h000;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   wire logic [31:0] rdat;
   wire logic ack;
   wire logic cv;
   wire logic [4:0] cch;
   wire logic [15:0] cd;
   wire logic [31:0] src;
   wire atrc_pkg::atrc_chan_vec_t trig;
   wire logic [4:0] hirq;
   wire logic cirq;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   always #2 clk = ~clk;
   atrc_core_model atrc_core_model_inst (.clk(clk), .conv_valid(cv), .conv_channel(cch),
      .conv_data(cd), .src(src));
   atrc_top atrc_top_inst (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .conv_valid(cv),
      .conv_channel(cch), .conv_data(cd), .sw_common_trig(src[1]), .sw_level_trig(src[2]),
      .pwm_trig(src[11:4]), .capture_compare_unit_irq(src[23:20]), .sec_pwm_trig2(src[27:24]),
      .logic_cell_one_pri(src[28]), .logic_cell_one_sec(src[29]), .trigger_sequencer(src[30]),
      .external_trigger_input(src[31]), .chan_trigger(trig), .chan_irq_high(hirq), .common_irq(cirq));
   task summarize;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         num_errors++;
         summarize;
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task bus(input logic w, input logic [8:0] a, input logic [15:0] d, output logic [15:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= {16'h0000, d};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      // no local limit: the ack, or else the bench timeout, ends the wait; the slave answers one cycle after acceptance
      chk("ack_wait", 2, n);
   endtask
   task wr(input logic [8:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask
   task rc(input string n, input logic [8:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(n, {16'h0000, e}, {16'h0000, q});
   endtask
   function logic [8:0] ta(int k);
      return 9'(`ATRC_OFS_TRIG_BASE + 4 * k);
   endfunction
   function logic [8:0] ca(int x, logic [8:0] o);
      return 9'(`ATRC_OFS_CMP_BASE + `ATRC_CMP_STRIDE * x + o);
   endfunction
   function logic [8:0] ra(int c);
      return 9'(`ATRC_OFS_RESULT_BASE + 4 * c);
   endfunction
   task t_reset;
      for (int k = 0; k < 11; k++)
         rc("trig_sel", ta(k), 16'h0000);
      rc("irq_en", `ATRC_OFS_IRQ_EN_HIGH, 16'h0000);
      rc("ready_lo", `ATRC_OFS_READY_LOW, 16'h0000);
      rc("ready_hi", `ATRC_OFS_READY_HIGH, 16'h0000);
      for (int x = 0; x < 4; x++)
      begin
         rc("con", ca(x, `ATRC_OFS_CMP_CON), 16'h0000);
         rc("mask_lo", ca(x, `ATRC_OFS_CMP_MASK_LOW), 16'h0000);
         rc("mask_hi", ca(x, `ATRC_OFS_CMP_MASK_HIGH), 16'h0000);
      end
      wr(9'h00C, 16'hFFFF);
      rc("unmapped", 9'h00C, 16'h0000);
   endtask
   task t_access;
      wr(`ATRC_OFS_IRQ_EN_HIGH, 16'hFFFF);
      rc("irq_en", `ATRC_OFS_IRQ_EN_HIGH, 16'h001F);
      wr(ta(0), 16'hFFFF);
      rc("trig_sel", ta(0), 16'h1F1F);
      wr(ta(10), 16'hFFFF);
      rc("trig_sel20", ta(10), 16'h001F);
      wr(`ATRC_OFS_READY_LOW, 16'hFFFF);
      rc("ready_ro", `ATRC_OFS_READY_LOW, 16'h0000);
      wr(ca(1, `ATRC_OFS_CMP_MASK_HIGH), 16'hFFFF);
      rc("mask_hi", ca(1, `ATRC_OFS_CMP_MASK_HIGH), 16'h001F);
      wr(ca(1, `ATRC_OFS_CMP_CON), 16'hFFFF);
      rc("con_rw", ca(1, `ATRC_OFS_CMP_CON), 16'h00DF);
      wr(ca(1, `ATRC_OFS_CMP_CON), 16'h0000);
      wr(ta(0), 16'h0000);
      wr(ta(10), 16'h0000);
      wr(`ATRC_OFS_IRQ_EN_HIGH, 16'h0002);
   endtask
   task t_ready;
      atrc_core_model_inst.convert(5'd3, 16'h1234);
      rc("ready_lo", `ATRC_OFS_READY_LOW, 16'h0008);
      rc("result", ra(3), 16'h1234);
      rc("ready_lo", `ATRC_OFS_READY_LOW, 16'h0000);
      atrc_core_model_inst.convert(5'd17, 16'hA5A5);
      @(posedge clk);
      #1 chk("irq_hi", 5'h02, hirq);
      chk("common", 1, cirq);
      atrc_core_model_inst.convert(5'd18, 16'h0001);
      @(posedge clk);
      #1 chk("irq_hi_masked", 5'h02, hirq);
      rc("ready_hi", `ATRC_OFS_READY_HIGH, 16'h0006);
      rc("result", ra(17), 16'hA5A5);
      rc("result", ra(18), 16'h0001);
      @(posedge clk);
      #1 chk("irq_hi_clear", 5'h00, hirq);
      chk("common_clear", 0, cirq);
   endtask
   task t_trig;
      logic e;
      for (int c = 0; c < 32; c++)
      begin
         wr(ta(0), {3'b000, 5'(c), 3'b000, 5'(c)});
         for (int s = 0; s < 32; s++)
         begin
            // reserved codes and none select nothing
            e = (s == c) && !(c == 0 || c == 3 || (c >= 12 && c <= 19));
            atrc_core_model_inst.set_src(32'h1 << s);
            repeat (4) @(posedge clk);
            #1 chk("chan_trigger", {19'h0, e, e}, 32'(trig));
            atrc_core_model_inst.set_src(32'h0);
            repeat (4) @(posedge clk);
         end
      end
      wr(ta(0), 16'h0000);
   endtask
   function logic evf(int m, logic [15:0] d);
      logic ge;
      logic lt;
      ge = d >= 16'h0100;
      lt = d < 16'h0200;
      case (m)
         4: return ge && lt;
         3: return !lt;
         2: return lt;
         1: return ge;
         default: return !ge;
      endcase
   endfunction
   task t_cmp;
      logic [15:0] dv [4];
      logic [4:0] last;
      logic ev;
      dv = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
      last = 5'h00;
      wr(ca(0, `ATRC_OFS_CMP_LOW_THR), 16'h0100);
      wr(ca(0, `ATRC_OFS_CMP_HIGH_THR), 16'h0200);
      wr(ca(0, `ATRC_OFS_CMP_MASK_LOW), 16'h0004);
      for (int m = 0; m < 5; m++)
         for (int i = 0; i < 4; i++)
         begin
            wr(ca(0, `ATRC_OFS_CMP_CON), 16'h00C0 | (16'h1 << m));
            atrc_core_model_inst.convert(5'd2, dv[i]);
            @(posedge clk);
            ev = evf(m, dv[i]);
            #1 chk("cmp_irq", {31'h0, ev}, {31'h0, cirq});
            if (ev)
               last = 5'd2;
            rc("cmp_con", ca(0, `ATRC_OFS_CMP_CON), {3'b000, last, 2'b11, ev, 5'(1 << m)});
            rc("cmp_con_rd", ca(0, `ATRC_OFS_CMP_CON), {3'b000, last, 3'b110, 5'(1 << m)});
         end
   endtask
   task t_misc;
      logic [15:0] q;
      wr(ca(3, `ATRC_OFS_CMP_MASK_HIGH), 16'h0010);
      wr(ca(3, `ATRC_OFS_CMP_CON), 16'h0082);
      atrc_core_model_inst.convert(5'd5, 16'h0007);
      rc("unmasked", ca(3, `ATRC_OFS_CMP_CON), 16'h0082);
      atrc_core_model_inst.convert(5'd20, 16'h0007);
      @(posedge clk);
      #1 chk("no_ie_irq", 0, cirq);
      rc("chan20", ca(3, `ATRC_OFS_CMP_CON), 16'h14A2);
      atrc_core_model_inst.convert(5'd20, 16'h0007);
      wr(ca(3, `ATRC_OFS_CMP_CON), 16'h0002);
      bus(1'b0, ca(3, `ATRC_OFS_CMP_CON), 16'h0000, q);
      chk("off_flag", 0, {31'h0, q[5]});
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_access;
      t_ready;
      t_trig;
      t_cmp;
      t_misc;
      summarize;
   end
endmodule
bind atrc_top atrc_sva atrc_sva_inst (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_data(conv_data),
   .sw_common_trig(sw_common_trig), .sw_level_trig(sw_level_trig), .pwm_trig(pwm_trig),
   .capture_compare_unit_irq(capture_compare_unit_irq), .sec_pwm_trig2(sec_pwm_trig2),
   .logic_cell_one_pri(logic_cell_one_pri), .logic_cell_one_sec(logic_cell_one_sec),
   .trigger_sequencer(trigger_sequencer), .external_trigger_input(external_trigger_input),
   .chan_trigger(chan_trigger), .chan_irq_high(chan_irq_high), .common_irq(common_irq));
